/* File: logic/mmh_unit.sv */
// Multi-processor resource handshake: executes test, request, release and set.
// Assumes one opcode word per instr_valid pulse, and the destination register
// value presented with it; register write-back goes out on rd_wr.
`timescale 1ns/1ps
module mmh_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic system_mode,
  input wire logic [15:0] rd_value,
  input wire logic grant_in_n,
  output logic busy,
  output logic done,
  output logic trap_priv,
  output logic flag_s,
  output logic flag_z,
  output logic flag_s_we,
  output logic flag_z_we,
  output logic rd_wr,
  output logic [3:0] rd_index,
  output logic [15:0] rd_wr_data,
  output logic request_out_n
);

  logic grant_n_s;
  mmh_pkg::mmh_state_e state;
  mmh_pkg::mmh_op_e op;
  logic [2:0] cnt;
  logic [15:0] dcount;
  logic made;

  logic is_test;
  logic is_req;
  logic is_rel;
  logic is_set;
  logic accept;
  logic priv_fail;
  logic start;
  logic step_end;
  logic sample1;
  logic last_step;
  logic finish;
  logic [15:0] next_count;

  mmh_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(grant_in_n),
    .dout(grant_n_s)
  );

  assign is_test = instr_word == mmh_pkg::OPC_TEST;
  assign is_req = instr_word[15:8] == mmh_pkg::OPC_REQ_HIGH
    && instr_word[3:0] == mmh_pkg::OPC_REQ_LOW;
  assign is_rel = instr_word == mmh_pkg::OPC_RELEASE;
  assign is_set = instr_word == mmh_pkg::OPC_SET;

  // Unknown words are not ours; the decoder routes them elsewhere
  assign accept = instr_valid && state == mmh_pkg::ST_IDLE
    && (is_test || is_req || is_rel || is_set);
  assign priv_fail = accept && (is_test || is_req) && !system_mode;
  assign start = accept && !priv_fail;
  assign step_end = cnt == 3'h0;
  assign sample1 = state == mmh_pkg::ST_HEAD && step_end;
  assign next_count = dcount - 16'h1;
  assign last_step = state == mmh_pkg::ST_DELAY && step_end && next_count == 16'h0;
  assign finish = step_end && (state == mmh_pkg::ST_WAIT || state == mmh_pkg::ST_TAIL);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= mmh_pkg::ST_IDLE;
      cnt <= 3'h0;
    end else begin
      unique case (state)
        mmh_pkg::ST_IDLE: begin
          if (start && is_req) begin
            state <= mmh_pkg::ST_HEAD;
            cnt <= mmh_pkg::LOAD_HEAD;
          end else if (start) begin
            state <= mmh_pkg::ST_WAIT;
            cnt <= is_test ? mmh_pkg::LOAD_TEST : mmh_pkg::LOAD_PIN;
          end
        end
        mmh_pkg::ST_WAIT, mmh_pkg::ST_TAIL: begin
          if (step_end) begin
            state <= mmh_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        mmh_pkg::ST_HEAD: begin
          if (step_end && grant_n_s) begin
            state <= mmh_pkg::ST_DELAY;
            cnt <= mmh_pkg::LOAD_STEP;
          end else if (step_end) begin
            state <= mmh_pkg::ST_TAIL;
            cnt <= mmh_pkg::LOAD_TAIL;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        mmh_pkg::ST_DELAY: begin
          if (last_step) begin
            state <= mmh_pkg::ST_TAIL;
            cnt <= mmh_pkg::LOAD_TAIL;
          end else if (step_end) begin
            cnt <= mmh_pkg::LOAD_STEP;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        default: begin
          state <= mmh_pkg::ST_IDLE;
          cnt <= 3'h0;
        end
      endcase
    end
  end

  // Instruction context and the delay count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op <= mmh_pkg::OP_TEST;
      made <= 1'b0;
      dcount <= 16'h0;
      rd_index <= 4'h0;
    end else if (start) begin
      op <= is_test ? mmh_pkg::OP_TEST : is_req ? mmh_pkg::OP_REQ
        : is_rel ? mmh_pkg::OP_RELEASE : mmh_pkg::OP_SET;
      made <= 1'b0;
      dcount <= rd_value;
      rd_index <= instr_word[mmh_pkg::RD_FIELD_LSB +: 4];
    end else if (sample1) begin
      made <= grant_n_s;
    end else if (state == mmh_pkg::ST_DELAY && step_end) begin
      dcount <= next_count;
    end
  end

  // register write-back per decrement
  // Zero on entry wraps and runs the full 65536 steps
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_wr <= 1'b0;
      rd_wr_data <= 16'h0;
    end else begin
      rd_wr <= state == mmh_pkg::ST_DELAY && step_end;
      rd_wr_data <= next_count;
    end
  end

  // Request pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      request_out_n <= mmh_pkg::REQUEST_RESET;
    end else if (start && is_set) begin
      request_out_n <= 1'b0;
    end else if (start && is_rel) begin
      request_out_n <= 1'b1;
    end else if (sample1) begin
      request_out_n <= !grant_n_s;
    end else if (last_step && grant_n_s) begin
      request_out_n <= 1'b1;
    end
  end

  // Sign flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_s <= 1'b0;
    end else if (finish && op == mmh_pkg::OP_TEST) begin
      flag_s <= grant_n_s;
    end else if (sample1 && !grant_n_s) begin
      flag_s <= 1'b0;
    end else if (last_step) begin
      flag_s <= !grant_n_s;
    end
  end

  // Zero flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_z <= 1'b0;
    end else if (start && is_req) begin
      flag_z <= 1'b0;
    end else if (finish && op == mmh_pkg::OP_REQ) begin
      flag_z <= made;
    end
  end

  // Busy level, trap strobe and completion strobes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      trap_priv <= 1'b0;
      flag_s_we <= 1'b0;
      flag_z_we <= 1'b0;
    end else begin
      busy <= (state == mmh_pkg::ST_IDLE) ? start : !finish;
      done <= finish;
      trap_priv <= priv_fail;
      flag_s_we <= finish && (op == mmh_pkg::OP_TEST || op == mmh_pkg::OP_REQ);
      flag_z_we <= finish && op == mmh_pkg::OP_REQ;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_test_timing: assert property (
    (start && is_test) |-> ##1 !done [*6] ##1 done)
    else $error("test instruction length wrong");

  chk_test_sign: assert property (
    (done && op == mmh_pkg::OP_TEST) |-> flag_s == $past(grant_n_s) && flag_s_we && !flag_z_we)
    else $error("test sign does not match grant");

  chk_zero_clear: assert property (
    (start && is_req) |-> ##1 !flag_z)
    else $error("zero not cleared at request start");

  chk_busy_outcome: assert property (
    (done && op == mmh_pkg::OP_REQ && !made) |-> !flag_s && !flag_z && request_out_n)
    else $error("not signalled outcome wrong");

  chk_grant_outcome: assert property (
    (done && op == mmh_pkg::OP_REQ && flag_s) |-> flag_z && !request_out_n)
    else $error("granted outcome wrong");

  chk_denied_outcome: assert property (
    (done && op == mmh_pkg::OP_REQ && made && !flag_s) |-> flag_z && request_out_n)
    else $error("denied outcome wrong");

  chk_step_spacing: assert property (
    (rd_wr && rd_wr_data != 16'h0) |-> ##1 !rd_wr [*6] ##1 rd_wr)
    else $error("decrement step not seven cycles");

  chk_skip_timing: assert property (
    (start && is_req) ##5 !grant_n_s |-> ##1 !done [*6] ##1 done)
    else $error("request without delay not twelve cycles");

  chk_release_pin: assert property (
    (start && is_rel) |-> ##1 request_out_n [*4] ##1 done)
    else $error("release pin or length wrong");

  chk_set_pin: assert property (
    (start && is_set) |-> ##1 !request_out_n [*4] ##1 done)
    else $error("set pin or length wrong");

  chk_priv_trap: assert property (
    priv_fail |-> ##1 trap_priv && !busy && request_out_n == $past(request_out_n)
      && flag_s == $past(flag_s) && flag_z == $past(flag_z))
    else $error("privileged trap touched state");

  chk_first_request: assert property (
    (sample1 && grant_n_s) |=> !request_out_n && state == mmh_pkg::ST_DELAY)
    else $error("request not raised on idle grant");

  chk_busy_skip: assert property (
    (sample1 && !grant_n_s) |=> !flag_s && request_out_n && state == mmh_pkg::ST_TAIL)
    else $error("busy grant did not skip the delay");

  chk_loop_exit: assert property (
    (rd_wr && rd_wr_data == 16'h0) |-> state == mmh_pkg::ST_TAIL)
    else $error("delay loop did not end at zero");

  chk_loop_stay: assert property (
    (rd_wr && rd_wr_data != 16'h0) |-> state == mmh_pkg::ST_DELAY)
    else $error("delay loop ended early");

  chk_grant_sign: assert property (
    (last_step && !grant_n_s) |=> flag_s && !request_out_n)
    else $error("granted request lost sign or pin");

  chk_request_withdrawn: assert property (
    (last_step && grant_n_s) |=> !flag_s && request_out_n)
    else $error("ungranted request not withdrawn");

  chk_made_zero: assert property (
    (done && op == mmh_pkg::OP_REQ && made) |-> flag_z && flag_z_we)
    else $error("made request did not set zero");

  chk_request_flags: assert property (
    (done && op == mmh_pkg::OP_REQ) |-> flag_s_we && flag_z_we && flag_z == made)
    else $error("request flags not delivered");

  // Five cycles on: the done cycle of set or release
  chk_pin_flags: assert property (
    (start && (is_set || is_rel)) |-> ##5 flag_s == $past(flag_s, 5)
      && flag_z == $past(flag_z, 5) && !flag_s_we && !flag_z_we)
    else $error("pin instruction changed flags");

  chk_test_zero: assert property (
    (start && is_test) |-> ##7 flag_z == $past(flag_z, 7))
    else $error("test instruction changed zero");

  chk_trap_mode: assert property (
    trap_priv |-> !$past(system_mode))
    else $error("trap raised in system mode");

endmodule

/* File: logic/mmh_pkg.sv */
// Constants for the multi-processor resource handshake unit.
// Assumes the CPU decoder hands over one 16-bit opcode word per instruction.
package mmh_pkg;

  localparam logic [15:0] OPC_TEST = 16'h7b0a;
  localparam logic [15:0] OPC_RELEASE = 16'h7b09;
  localparam logic [15:0] OPC_SET = 16'h7b08;
  localparam logic [7:0] OPC_REQ_HIGH = 8'h7b;
  localparam logic [3:0] OPC_REQ_LOW = 4'hd;
  localparam int RD_FIELD_LSB = 4;

  // Instruction, delay-step and head-phase lengths in clock cycles
  localparam int CYC_TEST = 7;
  localparam int CYC_PIN = 5;
  localparam int CYC_REQ_FIXED = 12;
  localparam int CYC_REQ_STEP = 7;
  localparam int CYC_REQ_HEAD = 5;

  // Counter loads: a phase of L cycles loads L-1; the done pulse adds one
  localparam logic [2:0] LOAD_TEST = 3'(CYC_TEST - 2);
  localparam logic [2:0] LOAD_PIN = 3'(CYC_PIN - 2);
  localparam logic [2:0] LOAD_HEAD = 3'(CYC_REQ_HEAD - 1);
  localparam logic [2:0] LOAD_TAIL = 3'(CYC_REQ_FIXED - CYC_REQ_HEAD - 2);
  localparam logic [2:0] LOAD_STEP = 3'(CYC_REQ_STEP - 1);

  localparam logic REQUEST_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h4,
    ST_HEAD = 3'h1,
    ST_DELAY = 3'h3,
    ST_TAIL = 3'h2
  } mmh_state_e;

  typedef enum logic [1:0] {
    OP_TEST = 2'h0,
    OP_REQ = 2'h1,
    OP_RELEASE = 2'h2,
    OP_SET = 2'h3
  } mmh_op_e;

endpackage

/* File: logic/mmh_sync.sv */
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk_sys.
`timescale 1ns/1ps
module mmh_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  logic meta;

  // Resets to the inactive high level of an active-low pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

/* File: testbench/mmh_partner.sv */
// Model of the other processor that shares the resource with this CPU.
// Assumes the grant line idles high through a pull-up and that the bench picks the mode.
`timescale 1ns/1ps
module mmh_partner #(
  parameter logic [2:0] ACK_DELAY = 3'h4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] grant_mode,
  input wire logic request_out_n,
  output logic grant_in_n
);
  logic [2:0] wait_cnt;

  // Mode 0 idle, 1 resource busy, 2 acknowledge a request after a delay
  // grant in time
  always_ff @(posedge clk_sys) begin
    if (rst || grant_mode == 2'h0) begin
      grant_in_n <= 1'b1;
      wait_cnt <= 3'h0;
    end else if (grant_mode == 2'h1) begin
      grant_in_n <= 1'b0;
    end else if (request_out_n) begin
      grant_in_n <= 1'b1;
      wait_cnt <= 3'h0;
    end else if (wait_cnt == ACK_DELAY) begin
      grant_in_n <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the resource handshake unit.
// Assumes the partner model answers on the grant pin as the bench selects.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic system_mode = 1'b1;
  logic [15:0] rd_value = 16'h0000;
  logic [1:0] grant_mode = 2'h0;
  logic grant_in_n, busy, done, trap_priv, flag_s, flag_z, flag_s_we, flag_z_we, rd_wr;
  logic request_out_n, trp, swe, zwe, low_seen, bsy, bsy_end;
  logic [3:0] rd_index;
  logic [15:0] rd_wr_data, last_wr;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int cyc, nwr;

  mmh_unit i_mmh_unit (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .system_mode(system_mode), .rd_value(rd_value),
    .grant_in_n(grant_in_n), .busy(busy), .done(done), .trap_priv(trap_priv),
    .flag_s(flag_s), .flag_z(flag_z), .flag_s_we(flag_s_we), .flag_z_we(flag_z_we),
    .rd_wr(rd_wr), .rd_index(rd_index), .rd_wr_data(rd_wr_data),
    .request_out_n(request_out_n));
  mmh_partner i_mmh_partner (.clk_sys(clk_sys), .rst(rst), .grant_mode(grant_mode),
    .request_out_n(request_out_n), .grant_in_n(grant_in_n));

  always #10 clk_sys = ~clk_sys;

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Issues one word and counts edges from the issue edge until done
  task automatic run_op(input logic [15:0] w, input logic sys, input logic [15:0] rdv);
    cyc = 0;
    nwr = 0;
    trp = 1'b0;
    low_seen = 1'b0;
    bsy = 1'b0;
    bsy_end = 1'b0;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    system_mode <= sys;
    rd_value <= rdv;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    // Trap pulse stands only between the issue edge and the next one
    #1;
    if (trap_priv === 1'b1)
      trp = 1'b1;
    for (int k = 1; k <= 120 && cyc == 0; k++) begin
      @(posedge clk_sys);
      #1;
      if (k == 1)
        bsy = busy;
      if (rd_wr === 1'b1) begin
        nwr++;
        last_wr = rd_wr_data;
      end
      if (trap_priv === 1'b1)
        trp = 1'b1;
      if (request_out_n === 1'b0)
        low_seen = 1'b1;
      if (done === 1'b1) begin
        // Done seen just after edge k is sampled at edge k+1
        cyc = k + 1;
        bsy_end = busy;
        swe = flag_s_we;
        zwe = flag_z_we;
      end
    end
  endtask

  task automatic test_grant_levels();
    for (int g = 0; g < 2; g++) begin
      @(posedge clk_sys);
      grant_mode <= g ? 2'h1 : 2'h0;
      repeat (4) @(posedge clk_sys);
      run_op(mmh_pkg::OPC_TEST, 1'b1, 16'h0000);
      check("test_cycles", cyc, 7);
      check("test_sign", flag_s, g ? 0 : 1);
      check("test_we", {swe, zwe}, 2'b10);
      check("test_busy", {bsy, bsy_end}, 2'b10);
    end
  endtask

  task automatic pin_ops();
    run_op(mmh_pkg::OPC_SET, 1'b0, 16'h0000);
    check("set_cycles", cyc, 5);
    check("set_pin", request_out_n, 1'b0);
    check("set_we", {swe, zwe}, 2'b00);
    run_op(mmh_pkg::OPC_TEST, 1'b0, 16'h0000);
    check("trap_test", {trp, request_out_n, cyc == 0}, 3'b101);
    run_op(16'h7b3d, 1'b0, 16'h0002);
    check("trap_request", {trp, request_out_n, cyc == 0, nwr == 0}, 4'b1011);
    run_op(mmh_pkg::OPC_RELEASE, 1'b0, 16'h0000);
    check("release_cycles", cyc, 5);
    check("release_pin", {request_out_n, swe, zwe}, 3'b100);
  endtask

  task automatic request_case(input string name, input logic [1:0] mode,
      input logic [15:0] rdv, input int n, input logic [2:0] szp);
    @(posedge clk_sys);
    grant_mode <= mode;
    repeat (4) @(posedge clk_sys);
    run_op(16'h7b5d, 1'b1, rdv);
    check({name, "_cycles"}, cyc, 12 + 7 * n);
    check({name, "_decrements"}, nwr, n);
    check({name, "_outcome"}, {flag_s, flag_z, request_out_n}, szp);
    check({name, "_we"}, {swe, zwe}, 2'b11);
    check({name, "_busy"}, {bsy, bsy_end}, 2'b10);
    if (n > 0) begin
      check({name, "_went_low"}, low_seen, 1'b1);
      check({name, "_reg"}, {rd_index, last_wr}, 20'h50000);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    test_grant_levels();
    pin_ops();
    request_case("refused", 2'h0, 16'h0002, 2, 3'b011);
    request_case("granted", 2'h2, 16'h0003, 3, 3'b110);
    request_case("busy", 2'h1, 16'h0003, 0, 3'b001);
    check("busy_zero_cleared", flag_z, 1'b0);
    finish_test();
  end
endmodule
